// ---- verilog/spkr_ctrl_pkg.sv ----
/*
 * constants, types and field layout for the speakerphone serial control
 * port and its mode-decision logic.
 * assumes a single core clock, ref_clk, at 250 MHz; serial lines async.
 */
package spkr_ctrl_pkg;

  // ***********************************************************
  // word layout
  // ***********************************************************
  localparam int unsigned WORD_W   = 8;
  localparam int unsigned VOL_LSB  = 0;
  localparam int unsigned VOL_W    = 4;
  localparam int unsigned MUTE_BIT = 4;
  localparam int unsigned RANGE_BIT = 5;
  localparam int unsigned MODE_LSB = 6;
  localparam int unsigned MODE_W   = 2;
  localparam logic [WORD_W-1:0] WORD_RST = 8'h00;
  localparam logic [3:0]  CNT_W1   = 4'h8;

  // ***********************************************************
  // modes
  // ***********************************************************
  typedef enum logic [1:0] {
    SEL_AUTO = 2'h0,
    SEL_RX   = 2'h1,
    SEL_IDLE = 2'h2,
    SEL_TX   = 2'h3
  } mode_sel_e;

  // gray along idle -> receive -> transmit
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RX   = 2'h1,
    ST_TX   = 2'h3
  } path_e;

endpackage : spkr_ctrl_pkg

// ---- verilog/spkr_pin_sync.sv ----
/*
 * three-flop synchroniser for one asynchronous pin.
 * assumes reset value given; output level takes stage 3 only when stages 2 and 3 agree.
 */
module spkr_pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_s;

  sync_s r_q;
  sync_s r_d;

  // stage chain; level moves only once stages 2 and 3 agree
  always_comb begin
    r_d     = r_q;
    r_d.s1  = pin;
    r_d.s2  = r_q.s1;
    r_d.s3  = r_q.s2;
    if (r_q.s2 == r_q.s3) begin
      r_d.lvl = r_q.s3;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r_q <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      r_q <= r_d;
    end
  end

  assign level = r_q.lvl;
  assign rise  = r_d.lvl & ~r_q.lvl;
  assign fall  = ~r_d.lvl & r_q.lvl;
endmodule // spkr_pin_sync

// ---- verilog/spkr_mode_fsm.sv ----
/*
 * automatic voice switching path decision plus forced-mode override.
 * assumes comparator and monitor flags already synchronised to ref_clk.
 */
module spkr_mode_fsm
  import spkr_ctrl_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  input  wire logic                clear,
  input  wire spkr_ctrl_pkg::mode_sel_e mode_sel,
  input  wire logic                rx_stronger,
  input  wire logic                tx_speech,
  input  wire logic                rx_speech,
  input  wire logic                dial_tone,
  output spkr_ctrl_pkg::path_e     path
);
  import spkr_ctrl_pkg::*;

  typedef struct packed {
    path_e st;
  } fsm_s;

  fsm_s r_q;
  fsm_s r_d;
  logic rx_speech_eff;

  // dial tone masks the receive noise monitor while receiving
  assign rx_speech_eff = rx_speech |
                         (dial_tone & (r_q.st == ST_RX));

  // automatic decision, overridden by forced modes
  always_comb begin
    r_d = r_q;
    case (mode_sel)
      SEL_AUTO: begin
        if (!tx_speech && !rx_speech_eff) begin
          r_d.st = ST_IDLE;
        end else if (rx_stronger) begin
          r_d.st = ST_RX;
        end else begin
          r_d.st = ST_TX;
        end
      end
      SEL_RX:   r_d.st = ST_RX;
      SEL_IDLE: r_d.st = ST_IDLE;
      SEL_TX:   r_d.st = ST_TX;
      default:  r_d.st = ST_IDLE;
    endcase
    if (clear) begin
      r_d.st = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r_q <= '{ST_IDLE};
    end else begin
      r_q <= r_d;
    end
  end

  assign path = r_q.st;
endmodule // spkr_mode_fsm

// ---- verilog/speakerphone_serial_control_port.sv ----
/*
 * serial control port: shift register, holding word, field decode and
 * path decision for a voice-switched speakerphone.
 * assumes serial clock, data, strobe and disable are asynchronous pins
 * sampled by ref_clk; comparator flags arrive as asynchronous levels.
 */
module speakerphone_serial_control_port
  import spkr_ctrl_pkg::*;
(
  input  wire logic                        ref_clk,
  input  wire logic                        resetn,
  input  wire logic                        ser_clk,
  input  wire logic                        ser_data,
  input  wire logic                        latch_strobe_n,
  input  wire logic                        power_down_pin,
  input  wire logic                        rx_stronger,
  input  wire logic                        tx_speech,
  input  wire logic                        rx_speech,
  input  wire logic                        dial_tone,
  output logic [spkr_ctrl_pkg::WORD_W-1:0] control_word,
  output logic [spkr_ctrl_pkg::VOL_W-1:0]  rx_volume,
  output logic                             mic_mute_bit,
  output logic                             range_select_bit,
  output spkr_ctrl_pkg::path_e             path
);
  import spkr_ctrl_pkg::*;

  // ***********************************************************
  // pin sampling
  // ***********************************************************
  logic sck_rise;
  logic strobe_lvl;
  logic strobe_rise;
  logic data_lvl;
  logic dis_lvl;
  logic dis_fall;
  logic rxs_lvl;
  logic txs_lvl;
  logic rxsp_lvl;
  logic dt_lvl;

  spkr_pin_sync #(.RST_VAL(1'b0)) u_sck (
    .ref_clk (ref_clk), .resetn (resetn), .pin (ser_clk),
    .level (), .rise (sck_rise), .fall ()
  );
  spkr_pin_sync #(.RST_VAL(1'b0)) u_sda (
    .ref_clk (ref_clk), .resetn (resetn), .pin (ser_data),
    .level (data_lvl), .rise (), .fall ()
  );
  spkr_pin_sync #(.RST_VAL(1'b1)) u_stb (
    .ref_clk (ref_clk), .resetn (resetn), .pin (latch_strobe_n),
    .level (strobe_lvl), .rise (strobe_rise), .fall ()
  );
  spkr_pin_sync #(.RST_VAL(1'b0)) u_dis (
    .ref_clk (ref_clk), .resetn (resetn), .pin (power_down_pin),
    .level (dis_lvl), .rise (), .fall (dis_fall)
  );
  spkr_pin_sync #(.RST_VAL(1'b0)) u_rxs (
    .ref_clk (ref_clk), .resetn (resetn), .pin (rx_stronger),
    .level (rxs_lvl), .rise (), .fall ()
  );
  spkr_pin_sync #(.RST_VAL(1'b0)) u_txs (
    .ref_clk (ref_clk), .resetn (resetn), .pin (tx_speech),
    .level (txs_lvl), .rise (), .fall ()
  );
  spkr_pin_sync #(.RST_VAL(1'b0)) u_rxsp (
    .ref_clk (ref_clk), .resetn (resetn), .pin (rx_speech),
    .level (rxsp_lvl), .rise (), .fall ()
  );
  spkr_pin_sync #(.RST_VAL(1'b0)) u_dt (
    .ref_clk (ref_clk), .resetn (resetn), .pin (dial_tone),
    .level (dt_lvl), .rise (), .fall ()
  );

  // ***********************************************************
  // shift and holding registers
  // ***********************************************************
  typedef struct packed {
    logic [WORD_W-1:0] shift;
    logic [WORD_W-1:0] hold;
  } port_s;

  port_s r_q;
  port_s r_d;

  // bits shift in on each serial clock rise and the holding word takes the
  // shifter on strobe rise, both only while disable is low; no address or framing is checked
  always_comb begin
    r_d = r_q;
    if (sck_rise && !dis_lvl) begin
      r_d.shift = {r_q.shift[WORD_W-2:0], data_lvl};
    end
    if (strobe_rise && !dis_lvl) begin
      r_d.hold = r_q.shift;
    end
    if (dis_fall) begin
      r_d.hold = WORD_RST;
    end
  end

  // asynchronous clear from power-on reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r_q <= '{WORD_RST, WORD_RST};
    end else begin
      r_q <= r_d;
    end
  end

  // ***********************************************************
  // mode decision
  // ***********************************************************
  mode_sel_e mode_sel;
  assign mode_sel = mode_sel_e'(r_q.hold[MODE_LSB +: MODE_W]);

  spkr_mode_fsm u_fsm (
    .ref_clk     (ref_clk),
    .resetn      (resetn),
    .clear       (dis_lvl),
    .mode_sel    (mode_sel),
    .rx_stronger (rxs_lvl),
    .tx_speech   (txs_lvl),
    .rx_speech   (rxsp_lvl),
    .dial_tone   (dt_lvl),
    .path        (path)
  );

  // ***********************************************************
  // field outputs
  // ***********************************************************
  assign control_word     = r_q.hold;
  assign mic_mute_bit     = r_q.hold[MUTE_BIT];
  assign range_select_bit = r_q.hold[RANGE_BIT];
  // volume passes only in receive; otherwise lowest code is neutral
  assign rx_volume = (path == ST_RX) ?
                     r_q.hold[VOL_LSB +: VOL_W] : '0;
endmodule // speakerphone_serial_control_port

// ---- dv/spkr_host_model.sv ----
/* host side of the three-line serial port: shifts one word per call.
   assumes the bench calls send only while the strobe idles high. */
module spkr_host_model (
  output logic ser_clk,
  output logic ser_data,
  output logic latch_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************
  // idle levels: clock parked low, strobe high
  // ************************************************
  initial begin
    ser_clk        = 1'b0;
    ser_data       = 1'b0;
    latch_strobe_n = 1'b1;
  end
  // one frame, 160 ns per bit, no header
  task automatic send(input logic [7:0] w);
    latch_strobe_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      ser_data = w[i];
      #40 ser_clk = 1'b1;
      #80 ser_clk = 1'b0;
      #40;
    end
    latch_strobe_n = 1'b1;
    ser_data       = ~w[0]; // no stale bit after the frame
  endtask
endmodule // spkr_host_model

// ---- dv/spkr_port_sva.sv ----
/* checker on the control port outputs.
   assumes binding to the port top module. */
module spkr_port_sva (
  input wire logic                 ref_clk,
  input wire logic                 resetn,
  input wire logic                 latch_strobe_n,
  input wire logic                 power_down_pin,
  input wire logic                 rx_stronger,
  input wire logic                 tx_speech,
  input wire logic                 rx_speech,
  input wire logic                 dial_tone,
  input wire logic [7:0]           control_word,
  input wire logic [3:0]           rx_volume,
  input wire logic                 mic_mute_bit,
  input wire logic                 range_select_bit,
  input wire spkr_ctrl_pkg::path_e path
);
  import spkr_ctrl_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_vol_gate: assert property (rx_volume ==
    (path == ST_RX ? control_word[3:0] : 4'h0)) else $error("volume");
  chk_field_bits: assert property (
    {mic_mute_bit, range_select_bit} ==
    {control_word[4], control_word[5]}) else $error("field bits");
  chk_reset_zero: assert property ($rose(resetn) |->
    (control_word == 8'h00) [*4]) else $error("reset word");
  chk_word_hold: assert property (
    ($stable(latch_strobe_n) &&
    !power_down_pin) [*8] |=> $stable(control_word)) else $error("hold");
  chk_disable_clear: assert property ($fell(power_down_pin) |->
    ##[1:8] control_word == 8'h00) else $error("disable clear");
  chk_disable_idle: assert property (power_down_pin [*8] |->
    path == ST_IDLE) else $error("disable path");
  chk_forced_mode: assert property (
    (control_word[7:6] != 2'h0 &&
    $stable(control_word) && !power_down_pin) [*8] |-> path ==
    (control_word[7:6] == 2'h1 ? ST_RX :
     control_word[7:6] == 2'h2 ? ST_IDLE : ST_TX)) else $error("forced");
  chk_auto_speech: assert property (
    (control_word[7:6] == 2'h0 &&
    tx_speech && rx_speech && $stable(rx_stronger) && !dial_tone &&
    !power_down_pin) [*8] |-> path == (rx_stronger ? ST_RX : ST_TX))
    else $error("auto speech");
  chk_auto_idle: assert property ((control_word[7:6] == 2'h0 &&
    !tx_speech && !rx_speech && !dial_tone) [*8] |-> path == ST_IDLE)
    else $error("auto idle");
  chk_dial_hold: assert property ((dial_tone && !power_down_pin &&
    control_word[7:6] == 2'h0) [*8] ##0 path == ST_RX |=>
    path != ST_IDLE) else $error("dial tone");
endmodule // spkr_port_sva
bind speakerphone_serial_control_port spkr_port_sva i_spkr_port_sva (
  .ref_clk, .resetn, .latch_strobe_n, .power_down_pin, .rx_stronger,
  .tx_speech, .rx_speech, .dial_tone, .control_word, .rx_volume,
  .mic_mute_bit, .range_select_bit, .path);

// ---- dv/speakerphone_serial_control_port_bench.sv ----
/* self-checking bench for the serial control port.
   assumes the host model and checker files are compiled first. */
module speakerphone_serial_control_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import spkr_ctrl_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, power_down_pin = 1'b0;
  logic rx_stronger = 1'b1, tx_speech = 1'b0, rx_speech = 1'b0;
  logic dial_tone = 1'b0, ser_clk, ser_data, latch_strobe_n;
  logic [7:0] control_word;
  logic [3:0] rx_volume;
  logic       mic_mute_bit, range_select_bit;
  path_e      path;
  int         failures = 0, compares = 0;
  logic [7:0] words [5] = '{8'h4a, 8'h95, 8'hf3, 8'h2c, 8'h00};
  path_e      paths [5] = '{ST_RX, ST_IDLE, ST_TX, ST_RX, ST_IDLE};
  always #2 ref_clk = ~ref_clk;
  spkr_host_model i_spkr_host_model (.ser_clk, .ser_data, .latch_strobe_n);
  speakerphone_serial_control_port i_speakerphone_serial_control_port (
    .ref_clk, .resetn, .ser_clk, .ser_data, .latch_strobe_n,
    .power_down_pin, .rx_stronger, .tx_speech, .rx_speech, .dial_tone,
    .control_word, .rx_volume, .mic_mute_bit, .range_select_bit, .path);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic put(input logic [7:0] w);
    i_spkr_host_model.send(w);
    tick(20);
  endtask
  task automatic stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // run guard
  initial begin
    #300000;
    failures++;
    stop_test();
  end
  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    tick(2);
    resetn = 1'b1;
    tick(8);
    check(control_word, 8'h00);
    foreach (words[k]) begin
      {tx_speech, rx_speech} = {2{k != 4}};
      put(words[k]);
      check(control_word, words[k]);
      check({6'h00, mic_mute_bit, range_select_bit},
            {6'h00, words[k][4], words[k][5]});
      check({6'h00, path},
            {6'h00, paths[k]});
      check({4'h0, rx_volume},
            {4'h0, ((paths[k] == ST_RX) ? words[k][3:0] : 4'h0)});
      $display("word test %h done", words[k]);
    end
    {tx_speech, rx_speech, rx_stronger} = 3'b110;
    tick(20);
    check({6'h00, path}, {6'h00, ST_TX});
    rx_stronger = 1'b1;
    tick(20);
    check({6'h00, path}, {6'h00, ST_RX});
    {dial_tone, tx_speech, rx_speech} = 3'b100;
    tick(20);
    check({6'h00, path}, {6'h00, ST_RX});
    dial_tone = 1'b0;
    tick(20);
    check({6'h00, path}, {6'h00, ST_IDLE});
    $display("auto test done");
    put(8'h4a);
    power_down_pin = 1'b1;
    put(8'h95);
    check(control_word, 8'h4a);
    check({6'h00, path}, {6'h00, ST_IDLE});
    power_down_pin = 1'b0;
    tick(20);
    check(control_word, 8'h00);
    $display("disable test done");
    put(8'h77);
    check(control_word, 8'h77);
    resetn = 1'b0;
    tick(2);
    check(control_word, 8'h00);
    resetn = 1'b1;
    tick(20);
    check(control_word, 8'h00);
    $display("reset test done");
    stop_test();
  end
endmodule // speakerphone_serial_control_port_bench
